/* File: include/scan_input_defs.vh */
// register map, field layout and limits of the process-data decoder
`ifndef SCAN_INPUT_DEFS_VH
`define SCAN_INPUT_DEFS_VH
`define REG_CTRL      12'h000
`define REG_INPUTS    12'h004
`define REG_SPEED     12'h008
`define REG_CASENUM   12'h00C
`define REG_CONFIG    12'h010
`define REG_STATUS    12'h014
`define CTRL_SWEN     0
`define CTRL_SLEEP    1
`define CTRL_SPDOK    2
`define CFG_ONEOFN    0
`define INPUTS_MSB 15
`define WORD_MSB 15
`define CASE_MSB 7
`define SPEED_MSB     11
`define SPEED_MAX     12'sh7D0
`define SPEED_MIN     12'sh830
`define CASE_INVALID  8'h00
`define CASE_MAX      8'hFE
`define CASE_NONE     8'h00
`define ZERO32        32'h00000000
`endif

/* File: logic/case_select_eval.v */
// evaluates the sixteen case-selection inputs into a case index
`timescale 1ns/1ps
module case_select_eval (
  // inputs
  input wire [15:0] inputs,
  input wire oneOfN,
  // result
  output reg [4:0] index,
  output reg valid
);
  integer i;
  reg [4:0] ones;
  reg pairsOk;
  always @* begin
    index = 5'h00;
    valid = 1'b0;
    ones = 5'h00;
    pairsOk = 1'b1;
    if (oneOfN) begin
      // exactly one input high selects that input
      for (i = 0; i < 16; i = i + 1) begin
        if (inputs[i]) begin
          ones = ones + 5'h01;
          index = i[4:0];
        end
      end
      valid = (ones == 5'h01);
    end else begin
      // each pair must be complementary; even members of pairs 0-3 give the four index bits
      for (i = 0; i < 8; i = i + 1) begin
        if (inputs[2*i] == inputs[2*i+1])
          pairsOk = 1'b0;
      end
      for (i = 0; i < 4; i = i + 1)
        index[i] = inputs[2*i];
      valid = pairsOk;
    end
  end
endmodule // case_select_eval

/* File: logic/scanner_input_process_data.v */
// apb-mapped decoder for the cyclic process data a controller sends
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "scan_input_defs.vh"
module scanner_input_process_data (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // decoded results
  output reg sleepActive,
  output reg caseSwitchActive,
  output reg [7:0] activeCase,
  output reg [4:0] selectIndex,
  output reg selectValid,
  output reg signed [15:0] safeSpeed,
  output reg speedUsable
);
  reg caseSwitchEnable;
  reg sleepRequest;
  reg safeSpeedOk;
  reg [15:0] caseSelectInputs;
  reg [15:0] safeSpeedWord;
  reg [7:0] caseNumberTableOne;
  reg oneOfNMode;
  wire [4:0] evalIndex;
  wire evalValid;
  reg [31:0] next_prdata;
  reg next_pslverr;
  wire apbTaken;
  wire apbCommit;
  wire signed [11:0] speedField;
  wire speedInRange;
  wire caseValid;

  function inRange;
    input signed [11:0] v;
    begin
      inRange = (v <= `SPEED_MAX) && (v >= `SPEED_MIN);
    end
  endfunction

  assign apbTaken = psel & penable & ~pready;
  // writes wait for the completing edge, so an aborted access changes nothing
  assign apbCommit = psel & penable & pready & pwrite;
  assign speedField = safeSpeedWord[`SPEED_MSB:0];
  assign speedInRange = inRange(speedField);
  assign caseValid = (caseNumberTableOne != `CASE_INVALID) &&
    (caseNumberTableOne <= `CASE_MAX);

  case_select_eval case_select_eval_inst (
    .inputs(caseSelectInputs),
    .oneOfN(oneOfNMode),
    .index(evalIndex),
    .valid(evalValid)
  );

  // read data and error answer for the access about to be taken
  always @* begin
    next_prdata = `ZERO32;
    next_pslverr = 1'b0;
    if (paddr == `REG_CTRL) begin
      if (!pwrite)
        next_prdata = {29'h00000000, safeSpeedOk, sleepRequest,
          caseSwitchEnable};
    end else if (paddr == `REG_INPUTS) begin
      if (!pwrite)
        next_prdata = {16'h0000, caseSelectInputs};
    end else if (paddr == `REG_SPEED) begin
      if (!pwrite)
        next_prdata = {16'h0000, safeSpeedWord};
    end else if (paddr == `REG_CASENUM) begin
      if (!pwrite)
        next_prdata = {24'h000000, caseNumberTableOne};
    end else if (paddr == `REG_CONFIG) begin
      if (!pwrite)
        next_prdata = {31'h00000000, oneOfNMode};
    end else if (paddr == `REG_STATUS) begin
      // read-only snapshot of decoded state
      if (pwrite)
        next_pslverr = 1'b1;
      else
        next_prdata = {8'h00, activeCase, speedUsable, selectValid,
          selectIndex, caseSwitchActive, sleepActive, 7'h00};
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // apb answer, one wait state: pready is high in the second access cycle
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `ZERO32;
    end else begin
      pready <= apbTaken;
      pslverr <= apbTaken & next_pslverr;
      if (apbTaken)
        prdata <= next_prdata;
    end
  end

  // process data words, written at the edge that sees pready high
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      caseSwitchEnable <= 1'b0;
      sleepRequest <= 1'b0;
      safeSpeedOk <= 1'b0;
      caseSelectInputs <= 16'h0000;
      safeSpeedWord <= 16'h0000;
      caseNumberTableOne <= `CASE_NONE;
      oneOfNMode <= 1'b0;
    end else if (apbCommit) begin
      if (paddr == `REG_CTRL) begin
        caseSwitchEnable <= pwdata[`CTRL_SWEN];
        sleepRequest <= pwdata[`CTRL_SLEEP];
        safeSpeedOk <= pwdata[`CTRL_SPDOK];
      end else if (paddr == `REG_INPUTS) begin
        caseSelectInputs <= pwdata[`INPUTS_MSB:0];
      end else if (paddr == `REG_SPEED) begin
        safeSpeedWord <= pwdata[`WORD_MSB:0];
      end else if (paddr == `REG_CASENUM) begin
        caseNumberTableOne <= pwdata[`CASE_MSB:0];
      end else if (paddr == `REG_CONFIG) begin
        oneOfNMode <= pwdata[`CFG_ONEOFN];
      end
    end
  end

  // sleep and switch state follow their request bits one cycle later
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sleepActive <= 1'b0;
      caseSwitchActive <= 1'b0;
    end else begin
      sleepActive <= sleepRequest;
      caseSwitchActive <= caseSwitchEnable;
    end
  end

  // selection freezes while switching is disabled
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      activeCase <= `CASE_NONE;
      selectIndex <= 5'h00;
      selectValid <= 1'b0;
    end else if (caseSwitchEnable) begin
      selectIndex <= evalIndex;
      selectValid <= evalValid;
      // an invalid number keeps the last valid case active
      if (caseValid)
        activeCase <= caseNumberTableOne;
    end
  end

  // invalid or out-of-range speed is reported as zero, unusable
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      safeSpeed <= 16'sh0000;
      speedUsable <= 1'b0;
    end else if (safeSpeedOk && speedInRange) begin
      safeSpeed <= {{4{speedField[`SPEED_MSB]}}, speedField};
      speedUsable <= 1'b1;
    end else begin
      safeSpeed <= 16'sh0000;
      speedUsable <= 1'b0;
    end
  end
endmodule // scanner_input_process_data

/* File: tb/scanner_input_process_data_chk.sv */
// assertions on the decoder ports
`timescale 1ns/1ps
`include "scan_input_defs.vh"
module scanner_input_process_data_chk (
  input wire clk_sys, nrst, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire sleepActive, caseSwitchActive, speedUsable,
  input wire [7:0] activeCase,
  input wire signed [15:0] safeSpeed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire ctlWr = psel && penable && pready && pwrite && paddr == `REG_CTRL;
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_slp; ctlWr |-> ##2 sleepActive == $past(pwdata[1], 2); endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_sw;
    ctlWr |-> ##2 caseSwitchActive == $past(pwdata[0], 2);
  endproperty
  a_sw: assert property (p_sw) else $error("switch");
  property p_frz; !caseSwitchActive |-> $stable(activeCase); endproperty
  a_frz: assert property (p_frz) else $error("case moved");
  property p_rng; activeCase != 8'hFF; endproperty
  a_rng: assert property (p_rng) else $error("case 255");
  property p_spd; speedUsable |-> safeSpeed >= -2000 && safeSpeed <= 2000;
  endproperty
  a_spd: assert property (p_spd) else $error("speed range");
  property p_ext; safeSpeed[15:11] == 5'h00 || safeSpeed[15:11] == 5'h1F;
  endproperty
  a_ext: assert property (p_ext) else $error("speed sign");
  property p_ro; pready && pwrite && paddr == `REG_STATUS |-> pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("status write");
  c_slp: cover property (ctlWr && pwdata[1]);
  c_spd: cover property (speedUsable);
  c_case: cover property ($changed(activeCase));
endmodule // scanner_input_process_data_chk
bind scanner_input_process_data scanner_input_process_data_chk
  scanner_input_process_data_chk_inst (.*);

/* File: tb/ctrl_sender.sv */
// apb master standing for the controller that sends process data
`timescale 1ns/1ps
module ctrl_sender (
  input wire clk_sys, pready, pslverr,
  input wire [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // call right after an edge; request held until ready is seen
  task xfer(input bit w, input [11:0] a, input [31:0] x,
    output [31:0] q, output e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge clk_sys) penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule // ctrl_sender

/* File: tb/scanner_input_process_data_test.sv */
// bench: apb stimulus against an integer model of the results
`timescale 1ns/1ps
`include "scan_input_defs.vh"
module scanner_input_process_data_test;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic sleepActive, caseSwitchActive, selectValid, speedUsable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [7:0] activeCase;
  logic [4:0] selectIndex;
  logic signed [15:0] safeSpeed;
  int failures, cmp_count, i, p, v, ok, ec;
  int cv[6] = '{5, 0, 255, 254, 1, 9};
  int sv[4] = '{32'hF7D0, 32'h0830, 32'h07D1, 32'hA82F};
  scanner_input_process_data scanner_input_process_data_inst (.*);
  ctrl_sender ctrl_sender_inst (.*);
  task chk(input string n, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task op(input bit w, input [11:0] a, input [31:0] x);
    ctrl_sender_inst.xfer(w, a, x, q, e);
    // write lands at the ready edge, decoded outputs one edge later
    repeat (2) @(posedge clk_sys);
  endtask
  task summarize();
    $display("%0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    nrst = 0;
    v = $urandom(32'hB5281A2C);
    repeat (8) @(posedge clk_sys);
    nrst <= 1;
    @(posedge clk_sys);
    chk("rst", {sleepActive, caseSwitchActive, activeCase, speedUsable}, 0);
    for (i = 0; i < 8; i++) begin
      op(1, `REG_CTRL, i);
      chk("sw", caseSwitchActive, i % 2);
      chk("slp", sleepActive, i / 2 % 2);
      op(0, `REG_CTRL, 0);
      chk("ctl", q, i);
    end
    $display("ctrl done");
    op(1, `REG_CTRL, 1);
    for (i = 0; i < 6; i++) begin
      if (i == 5) op(1, `REG_CTRL, 0);
      op(1, `REG_CASENUM, cv[i]);
      if (i < 5 && cv[i] % 255) ec = cv[i];
      chk("case", activeCase, ec);
    end
    $display("case done");
    for (i = 0; i < 24; i++) begin
      d = i < 4 ? sv[i] : $urandom;
      ok = $urandom % 2;
      op(1, `REG_CTRL, ok * 4);
      op(1, `REG_SPEED, d);
      v = $signed(d[11:0]);
      chk("ok", speedUsable, ok && v >= -2000 && v <= 2000);
      chk("spd", safeSpeed, ok && v >= -2000 && v <= 2000 ? v : 0);
    end
    $display("speed done");
    op(1, `REG_CTRL, 1);
    for (i = 0; i < 32; i++) begin
      p = $urandom % 16;
      op(1, `REG_CONFIG, i % 2);
      d = i % 2 ? 1 << p : ($urandom % 2 ? 32'h5555 : 32'hAAAA);
      op(1, `REG_INPUTS, d ^ (i % 4 > 1 ? 1 << (p ^ 1) : 0));
      chk("val", selectValid, i % 4 < 2);
      if (i % 4 == 1) chk("idx", selectIndex, p);
      if (i % 4 == 0) chk("pidx", selectIndex, d[0] ? 15 : 0);
    end
    $display("select done");
    op(0, `REG_STATUS, 0);
    chk("st", q[23:16], cv[5]);
    chk("ste", e, 0);
    op(0, 12'h018, 0);
    chk("err", e, 1);
    chk("rd0", q, 0);
    op(1, `REG_STATUS, 0);
    chk("ro", e, 1);
    $display("map done");
    summarize();
  end
endmodule // scanner_input_process_data_test
